// [irq_flags_regs.svh]
// Offsets, bit positions and reset values of the interrupt flag bank.
// Function
// - Flag reads 1 after request, else 0
// - Flags read/write, zero after reset
// - Unimplemented bits read 0, ignore writes
// - Group two: timer6 bit15, dma4 bit14
// - Group two: compare 8..5 at bits 12..9
// - Group two: capture 6..3 at bits 8..5
// - Group two: dma3 done at bit 4
// - Group two: can A event 3, rx 2
// - Group two: serial B event 1, error 0
// - Group three: fault A 15, dma5 13
// - Group three: quadrature 10, pwm error 9
// - Group three: can B event 8, rx 7
// - Group three: ext input4 6, input3 5
// - Group three: timers 9, 8, 7 at 4, 3, 0
// - Group three: twowire B master 2, slave 1
// - Flag interrupts only while enable bit set
// - Polarity 1 negative edge, 0 positive
`ifndef IRQ_FLAGS_REGS_SVH
`define IRQ_FLAGS_REGS_SVH

// ---------------------------------------------------------------------
// Register word addresses
// ---------------------------------------------------------------------
`define ADDR_FLAGS_TWO 3'h0
`define ADDR_FLAGS_THREE 3'h1
`define ADDR_ENABLE_TWO 3'h2
`define ADDR_ENABLE_THREE 3'h3
`define ADDR_EDGE_POL 3'h4
`define ADDR_ACTIVE 3'h5

// ---------------------------------------------------------------------
// Masks and reset values
// ---------------------------------------------------------------------
`define IMPL_TWO 16'hDFFF
`define IMPL_THREE 16'hA7FF
`define POL_MASK 16'h0018
`define RESET_VAL 16'h0000

// ---------------------------------------------------------------------
// Group two bit positions
// ---------------------------------------------------------------------
`define B2_TIMER6 15
`define B2_DMA4 14
`define B2_CMP8 12
`define B2_CMP7 11
`define B2_CMP6 10
`define B2_CMP5 9
`define B2_CAP6 8
`define B2_CAP5 7
`define B2_CAP4 6
`define B2_CAP3 5
`define B2_DMA3 4
`define B2_CAN_A_EVT 3
`define B2_CAN_A_RX 2
`define B2_SER_B_EVT 1
`define B2_SER_B_ERR 0

// ---------------------------------------------------------------------
// Group three and polarity bit positions
// ---------------------------------------------------------------------
`define B3_FAULT_A 15
`define B3_DMA5 13
`define B3_QUAD 10
`define B3_PWM_ERR 9
`define B3_CAN_B_EVT 8
`define B3_CAN_B_RX 7
`define B3_EXT4 6
`define B3_EXT3 5
`define B3_TIMER9 4
`define B3_TIMER8 3
`define B3_TWI_B_MST 2
`define B3_TWI_B_SLV 1
`define B3_TIMER7 0
`define P_EXT4 4
`define P_EXT3 3

`endif

// [irq_flags_pkg.sv]
// Types shared by the interrupt flag bank and its users.
package irq_flags_pkg;

  // -------------------------------------------------------------------
  // Register port request
  // -------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

  // -------------------------------------------------------------------
  // Peripheral request pulses, one per flag source except the two external input pins
  // -------------------------------------------------------------------
  typedef struct packed {
    logic timer6;
    logic dma4;
    logic cmp8;
    logic cmp7;
    logic cmp6;
    logic cmp5;
    logic cap6;
    logic cap5;
    logic cap4;
    logic cap3;
    logic dma3;
    logic can_a_evt;
    logic can_a_rx;
    logic ser_b_evt;
    logic ser_b_err;
    logic fault_a;
    logic dma5;
    logic quad;
    logic pwm_err;
    logic can_b_evt;
    logic can_b_rx;
    logic timer9;
    logic timer8;
    logic timer7;
    logic twi_b_mst;
    logic twi_b_slv;
  } irq_src_t;

endpackage

// [irq_flag_bank.sv]
// Interrupt flag groups two and three with enables and edge inputs.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "irq_flags_regs.svh"

module irq_flag_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire irq_flags_pkg::bus_req_t bus,
  output logic [15:0] rdata,
  // Peripheral requests
  input wire irq_flags_pkg::irq_src_t src,
  // External interrupt pins, bit 0 input 3, bit 1 input 4
  input wire logic [1:0] ext_in,
  // Interrupt request to the core
  output logic irq
);
  import irq_flags_pkg::*;

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  logic [15:0] flags_two_q;
  logic [15:0] flags_two_d;
  logic [15:0] flags_three_q;
  logic [15:0] flags_three_d;
  logic [15:0] en_two_q;
  logic [15:0] en_three_q;
  logic [15:0] pol_q;
  logic [15:0] rdata_q;
  logic [1:0] ext_prev_q;
  logic ext_valid_q;
  logic [1:0] ext_hit;
  logic [15:0] set_two;
  logic [15:0] set_three;
  logic wr_two;
  logic wr_three;

  // -------------------------------------------------------------------
  // Source mapping
  // -------------------------------------------------------------------
  function automatic logic [15:0] map_two(input irq_src_t s);
    logic [15:0] v;
    v = `RESET_VAL;
    v[`B2_TIMER6] = s.timer6;
    v[`B2_DMA4] = s.dma4;
    v[`B2_CMP8] = s.cmp8;
    v[`B2_CMP7] = s.cmp7;
    v[`B2_CMP6] = s.cmp6;
    v[`B2_CMP5] = s.cmp5;
    v[`B2_CAP6] = s.cap6;
    v[`B2_CAP5] = s.cap5;
    v[`B2_CAP4] = s.cap4;
    v[`B2_CAP3] = s.cap3;
    v[`B2_DMA3] = s.dma3;
    v[`B2_CAN_A_EVT] = s.can_a_evt;
    v[`B2_CAN_A_RX] = s.can_a_rx;
    v[`B2_SER_B_EVT] = s.ser_b_evt;
    v[`B2_SER_B_ERR] = s.ser_b_err;
    return v;
  endfunction

  function automatic logic [15:0] map_three(input irq_src_t s,
                                            input logic [1:0] e);
    logic [15:0] v;
    v = `RESET_VAL;
    v[`B3_FAULT_A] = s.fault_a;
    v[`B3_DMA5] = s.dma5;
    v[`B3_QUAD] = s.quad;
    v[`B3_PWM_ERR] = s.pwm_err;
    v[`B3_CAN_B_EVT] = s.can_b_evt;
    v[`B3_CAN_B_RX] = s.can_b_rx;
    v[`B3_EXT4] = e[1];
    v[`B3_EXT3] = e[0];
    v[`B3_TIMER9] = s.timer9;
    v[`B3_TIMER8] = s.timer8;
    v[`B3_TIMER7] = s.timer7;
    v[`B3_TWI_B_MST] = s.twi_b_mst;
    v[`B3_TWI_B_SLV] = s.twi_b_slv;
    return v;
  endfunction

  // -------------------------------------------------------------------
  // External edge detection
  // -------------------------------------------------------------------
  // The first sample after reset only primes the history, so a pin
  // already high at reset does not look like an edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_prev_q <= 2'h0;
      ext_valid_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_in;
      ext_valid_q <= 1'b1;
    end
  end

  // polarity picks falling or rising edge
  always_comb begin
    ext_hit[0] = ext_valid_q & (pol_q[`P_EXT3] ?
                 (ext_prev_q[0] & ~ext_in[0]) :
                 (~ext_prev_q[0] & ext_in[0]));
    ext_hit[1] = ext_valid_q & (pol_q[`P_EXT4] ?
                 (ext_prev_q[1] & ~ext_in[1]) :
                 (~ext_prev_q[1] & ext_in[1]));
  end

  // -------------------------------------------------------------------
  // Flag update
  // -------------------------------------------------------------------
  assign wr_two = bus.wr && (bus.addr == `ADDR_FLAGS_TWO);
  assign wr_three = bus.wr && (bus.addr == `ADDR_FLAGS_THREE);
  assign set_two = map_two(src);
  assign set_three = map_three(src, ext_hit);

  // write loads, request ORed on top wins
  always_comb begin
    flags_two_d = wr_two ? bus.wdata : flags_two_q;
    flags_two_d = (flags_two_d | set_two) & `IMPL_TWO;
    flags_three_d = wr_three ? bus.wdata : flags_three_q;
    flags_three_d = (flags_three_d | set_three) & `IMPL_THREE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_two_q <= `RESET_VAL;
      flags_three_q <= `RESET_VAL;
    end else begin
      flags_two_q <= flags_two_d;
      flags_three_q <= flags_three_d;
    end
  end

  // -------------------------------------------------------------------
  // Enable and polarity registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_two_q <= `RESET_VAL;
      en_three_q <= `RESET_VAL;
      pol_q <= `RESET_VAL;
    end else if (bus.wr) begin
      if (bus.addr == `ADDR_ENABLE_TWO) begin
        en_two_q <= bus.wdata & `IMPL_TWO;
      end
      if (bus.addr == `ADDR_ENABLE_THREE) begin
        en_three_q <= bus.wdata & `IMPL_THREE;
      end
      if (bus.addr == `ADDR_EDGE_POL) begin
        pol_q <= bus.wdata & `POL_MASK;
      end
    end
  end

  // -------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------
  // flags read back as held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= `RESET_VAL;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `ADDR_FLAGS_TWO: rdata_q <= flags_two_q;
        `ADDR_FLAGS_THREE: rdata_q <= flags_three_q;
        `ADDR_ENABLE_TWO: rdata_q <= en_two_q;
        `ADDR_ENABLE_THREE: rdata_q <= en_three_q;
        `ADDR_EDGE_POL: rdata_q <= pol_q;
        `ADDR_ACTIVE: rdata_q <= {14'h0000, |(flags_three_q & en_three_q),
                                  |(flags_two_q & en_two_q)};
        default: rdata_q <= `RESET_VAL;
      endcase
    end else begin
      rdata_q <= `RESET_VAL;
    end
  end

  assign rdata = rdata_q;

  // -------------------------------------------------------------------
  // Interrupt output
  // -------------------------------------------------------------------
  // only enabled flags reach the core
  assign irq = |(flags_two_q & en_two_q) | |(flags_three_q & en_three_q);

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_reset_clears: assert property (@(posedge clk)
    !rst_n |=> (flags_two_q == `RESET_VAL) && (flags_three_q == `RESET_VAL))
    else $error("flags not clear after reset");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ((flags_two_q & ~`IMPL_TWO) == `RESET_VAL) &&
    ((flags_three_q & ~`IMPL_THREE) == `RESET_VAL))
    else $error("unimplemented flag bit set");

  a_timer6_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (src.timer6 && wr_two && !bus.wdata[`B2_TIMER6])
    |=> flags_two_q[`B2_TIMER6])
    else $error("timer6 request lost against write");

  a_write_loads: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_two && set_two == `RESET_VAL)
    |=> flags_two_q == ($past(bus.wdata) & `IMPL_TWO))
    else $error("group two write not loaded");

  a_compare8_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.cmp8 |=> flags_two_q[`B2_CMP8] ##1 flags_two_q[`B2_CMP8] || wr_two)
    else $error("compare8 flag wrong position");

  a_capture3_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.cap3 |=> flags_two_q[`B2_CAP3])
    else $error("capture3 flag not set");

  a_dma3_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.dma3 |=> flags_two_q[`B2_DMA3])
    else $error("dma3 flag not set");

  a_can_a_rx: assert property (@(posedge clk) disable iff (!rst_n)
    src.can_a_rx |=> flags_two_q[`B2_CAN_A_RX])
    else $error("can A rx flag not set");

  a_serial_err: assert property (@(posedge clk) disable iff (!rst_n)
    src.ser_b_err |=> flags_two_q[`B2_SER_B_ERR])
    else $error("serial B error flag not set");

  a_fault_a_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.fault_a |=> flags_three_q[`B3_FAULT_A])
    else $error("fault A flag not set");

  a_quad_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.quad |=> flags_three_q[`B3_QUAD])
    else $error("quadrature flag not set");

  a_can_b_rx: assert property (@(posedge clk) disable iff (!rst_n)
    src.can_b_rx |=> flags_three_q[`B3_CAN_B_RX])
    else $error("can B rx flag not set");

  a_ext3_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_valid_q && !pol_q[`P_EXT3] && !ext_prev_q[0] && ext_in[0])
    |=> flags_three_q[`B3_EXT3])
    else $error("ext input3 rising edge missed");

  a_ext4_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_valid_q && pol_q[`P_EXT4] && ext_prev_q[1] && !ext_in[1])
    |=> flags_three_q[`B3_EXT4])
    else $error("ext input4 falling edge missed");

  a_timer7_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.timer7 |=> flags_three_q[`B3_TIMER7])
    else $error("timer7 flag not set");

  a_twi_slave: assert property (@(posedge clk) disable iff (!rst_n)
    src.twi_b_slv |=> flags_three_q[`B3_TWI_B_SLV])
    else $error("twowire B slave flag not set");

  a_irq_gated: assert property (@(posedge clk) disable iff (!rst_n)
    (en_two_q == `RESET_VAL && en_three_q == `RESET_VAL) |-> !irq)
    else $error("interrupt raised with all enables clear");

  a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && bus.addr == `ADDR_FLAGS_THREE)
    |=> rdata == $past(flags_three_q))
    else $error("group three read data wrong");

  a_dma4_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.dma4 |=> flags_two_q[`B2_DMA4])
    else $error("dma4 flag not set");

  a_compare5_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.cmp5 |=> flags_two_q[`B2_CMP5])
    else $error("compare5 flag not set");

  a_capture6_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.cap6 |=> flags_two_q[`B2_CAP6])
    else $error("capture6 flag not set");

  a_can_a_evt: assert property (@(posedge clk) disable iff (!rst_n)
    src.can_a_evt |=> flags_two_q[`B2_CAN_A_EVT])
    else $error("can A event flag not set");

  a_serial_evt: assert property (@(posedge clk) disable iff (!rst_n)
    src.ser_b_evt |=> flags_two_q[`B2_SER_B_EVT])
    else $error("serial B event flag not set");

  a_dma5_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.dma5 |=> flags_three_q[`B3_DMA5])
    else $error("dma5 flag not set");

  a_pwm_err_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.pwm_err |=> flags_three_q[`B3_PWM_ERR])
    else $error("pwm error flag not set");

  a_can_b_evt: assert property (@(posedge clk) disable iff (!rst_n)
    src.can_b_evt |=> flags_three_q[`B3_CAN_B_EVT])
    else $error("can B event flag not set");

  a_timer9_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.timer9 |=> flags_three_q[`B3_TIMER9])
    else $error("timer9 flag not set");

  a_timer8_pos: assert property (@(posedge clk) disable iff (!rst_n)
    src.timer8 |=> flags_three_q[`B3_TIMER8])
    else $error("timer8 flag not set");

  a_twi_master: assert property (@(posedge clk) disable iff (!rst_n)
    src.twi_b_mst |=> flags_three_q[`B3_TWI_B_MST])
    else $error("twowire B master flag not set");

  a_enable_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ((en_two_q & ~`IMPL_TWO) == `RESET_VAL) &&
    ((en_three_q & ~`IMPL_THREE) == `RESET_VAL))
    else $error("unimplemented enable bit set");

  a_unmapped_rd: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && bus.addr > `ADDR_ACTIVE) |=> rdata == `RESET_VAL)
    else $error("unmapped address read not zero");

  a_irq_raised: assert property (@(posedge clk) disable iff (!rst_n)
    (flags_three_q[`B3_TIMER7] && en_three_q[`B3_TIMER7]) |-> irq)
    else $error("enabled timer7 flag gave no interrupt");

  a_ext3_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_valid_q && pol_q[`P_EXT3] && ext_prev_q[0] && !ext_in[0])
    |=> flags_three_q[`B3_EXT3])
    else $error("ext input3 falling edge missed");

  a_ext4_rise: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_valid_q && !pol_q[`P_EXT4] && !ext_prev_q[1] && ext_in[1])
    |=> flags_three_q[`B3_EXT4])
    else $error("ext input4 rising edge missed");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !bus.rd |=> rdata == `RESET_VAL)
    else $error("read data not zero without a read");

  a_clear_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_three && bus.wdata == `RESET_VAL && set_three == `RESET_VAL)
    |=> flags_three_q == `RESET_VAL)
    else $error("group three flags not cleared by write");

endmodule

// [periph_model.sv]
// Peripheral request sources facing the interrupt flag bank.
`timescale 1ns/1ps

module periph_model (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic go,
  input wire irq_flags_pkg::irq_src_t pattern,
  input wire logic [1:0] level,
  // Requests towards the bank
  output irq_flags_pkg::irq_src_t src,
  output logic [1:0] ext_in
);
  import irq_flags_pkg::*;

  always @(posedge clk) begin
    src <= go ? pattern : '0;
  end

  // pins are levels, so only a change makes an edge.
  always @(posedge clk) begin
    ext_in <= level;
  end
endmodule

// [irq_flag_bank_bench.sv]
// Self-checking bench for the interrupt flag bank.
`timescale 1ns/1ps
`include "irq_flags_regs.svh"

module irq_flag_bank_bench;
  import irq_flags_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bus_req_t bus = '0;
  logic [15:0] rdata;
  irq_src_t src;
  logic [1:0] ext_in;
  logic irq;
  logic go = 1'b0;
  irq_src_t pattern = '0;
  logic [1:0] level = 2'b00;
  logic [15:0] seed = 16'hfea5;
  logic [15:0] e2, e3, f2, f3;
  int fail_count = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  irq_flag_bank irq_flag_bank_i (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .src(src), .ext_in(ext_in), .irq(irq));
  periph_model periph_model_i (.clk(clk), .go(go), .pattern(pattern),
    .level(level), .src(src), .ext_in(ext_in));

  // ---------------------------------------------------------------------
  // Expectation helpers
  // ---------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] map_two(input irq_src_t s);
    return {s.timer6, s.dma4, 1'b0, s.cmp8, s.cmp7, s.cmp6, s.cmp5, s.cap6,
      s.cap5, s.cap4, s.cap3, s.dma3, s.can_a_evt, s.can_a_rx, s.ser_b_evt,
      s.ser_b_err};
  endfunction

  function automatic logic [15:0] map_three(input irq_src_t s);
    return {s.fault_a, 1'b0, s.dma5, 2'b00, s.quad, s.pwm_err, s.can_b_evt,
      s.can_b_rx, 2'b00, s.timer9, s.timer8, s.twi_b_mst, s.twi_b_slv,
      s.timer7};
  endfunction

  // ---------------------------------------------------------------------
  // Bus cycles and comparison
  // ---------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp,
      input string what);
    @(posedge clk);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask

  task automatic pulse(input irq_src_t p);
    @(posedge clk);
    go <= 1'b1;
    pattern <= p;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial begin
    irq_src_t p;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000, "reset value");
    wr(`ADDR_FLAGS_TWO, 16'hffff);
    wr(`ADDR_FLAGS_THREE, 16'hffff);
    wr(3'h6, 16'hffff);
    rd(`ADDR_FLAGS_TWO, 16'hdfff, "flags two ones");
    rd(`ADDR_FLAGS_THREE, 16'ha7ff, "flags three ones");
    rd(3'h6, 16'h0000, "unmapped");
    check("irq masked", 16'h0000, {15'h0000, irq});
    wr(`ADDR_ENABLE_THREE, 16'h0001);
    #1 check("irq enabled", 16'h0001, {15'h0000, irq});
    wr(`ADDR_FLAGS_TWO, 16'h0000);
    wr(`ADDR_FLAGS_THREE, 16'h0000);
    rd(`ADDR_FLAGS_THREE, 16'h0000, "cleared");
    check("irq cleared", 16'h0000, {15'h0000, irq});
    // Random requests and enables; the first pass raises every source.
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      e2 = seed;
      seed = lfsr(seed);
      e3 = seed;
      p = (i == 0) ? '1 : irq_src_t'({e2[9:0], e3});
      wr(`ADDR_ENABLE_TWO, e2);
      wr(`ADDR_ENABLE_THREE, e3);
      pulse(p);
      f2 = map_two(p);
      f3 = map_three(p);
      rd(`ADDR_ENABLE_TWO, e2 & 16'hdfff, "enable two");
      rd(`ADDR_ENABLE_THREE, e3 & 16'ha7ff, "enable three");
      rd(`ADDR_FLAGS_TWO, f2, "flags two");
      rd(`ADDR_FLAGS_THREE, f3, "flags three");
      check("irq", {15'h0000, |(f2 & e2) | |(f3 & e3)}, {15'h0000, irq});
      rd(`ADDR_ACTIVE, {14'h0000, |(f3 & e3), |(f2 & e2)}, "active");
      wr(`ADDR_FLAGS_TWO, 16'h0000);
      wr(`ADDR_FLAGS_THREE, 16'h0000);
    end
    // Request in the same cycle as a clearing write.
    @(posedge clk);
    go <= 1'b1;
    pattern <= '1;
    @(posedge clk);
    go <= 1'b0;
    bus <= '{rd: 1'b0, wr: 1'b1, addr: `ADDR_FLAGS_TWO, wdata: 16'h0000};
    @(posedge clk);
    bus.wr <= 1'b0;
    rd(`ADDR_FLAGS_TWO, 16'hdfff, "request beats write");
    // Both polarities on both external inputs.
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_EDGE_POL, {11'h000, i[1:0], 3'b000});
      level <= i[1:0];
      repeat (3) @(posedge clk);
      rd(`ADDR_EDGE_POL, {11'h000, i[1:0], 3'b000}, "polarity");
      wr(`ADDR_FLAGS_THREE, 16'h0000);
      level <= ~i[1:0];
      repeat (3) @(posedge clk);
      rd(`ADDR_FLAGS_THREE, 16'h0060, "active edge");
      wr(`ADDR_FLAGS_THREE, 16'h0000);
      level <= i[1:0];
      repeat (3) @(posedge clk);
      rd(`ADDR_FLAGS_THREE, 16'h0000, "inactive edge");
    end
    // A second reset in mid-run must clear what software set.
    wr(`ADDR_FLAGS_TWO, 16'hffff);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADDR_FLAGS_TWO, 16'h0000, "second reset");
    rd(`ADDR_ENABLE_TWO, 16'h0000, "enable after reset");
    check("irq after reset", 16'h0000, {15'h0000, irq});
    report_and_stop();
  end

  // Runs take about a thousand cycles; this span of 20000 cycles is far beyond that.
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule
